// *** logic/srs_startup_reset_sequencer.sv ***
// Start-up and reset sequencer: power wait, start-up clock, calibration load, core release
// Behaviour
// - Hold whole chip in reset until power has been stable.
// - After power is stable run from internal oscillator divided by eight.
// - Generator 0 output is the power manager main clock.
// - Default synchronous clocks start undivided from generator 0.
// - Only the watchdog generic clock channel is enabled at start-up.
// - All I/O pins stay undriven until software configures them.
// - Processor fetches its start vectors from address zero, the flash start.
// - Power-on monitor is always enabled and cannot be switched off.
// - Power-on monitor undervoltage resets the entire chip.
// - Core supply brown-out monitor is armed only after start-up completes.
// - Each automatic calibration word is written to its register at start-up.
// - Bus address regions are fixed and never remapped.
// - Regulator runs normal while active, low power only in standby.
// - User row values take effect only at the next reset load.
`timescale 1ns/1ps
`default_nettype none
module srs_startup_reset_sequencer (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Analog monitors and oscillator pins
    input wire logic power_stable_in,
    input wire logic por_below_threshold_in,
    input wire logic core_brownout_in,
    input wire logic internal_rc_oscillator_in,
    // Standby request from the power manager
    input wire logic standby_req_in,
    // Nonvolatile memory read port
    output var srs_pkg::srs_nvm_req_s nvm_req_out,
    input wire srs_pkg::srs_nvm_rsp_s nvm_rsp_in,
    // Calibration and user configuration
    output var srs_pkg::srs_cal_write_s cal_write_out,
    output logic [63:0] user_cfg_out,
    output logic user_cfg_valid_out,
    // Clock control
    output logic gclk0_clk_out,
    output logic [3:0] pm_clk_src_out,
    output logic [2:0] sync_clk_div_out,
    output logic [srs_pkg::GCLK_CHANNELS-1:0] gclk_chan_en_out,
    // Resets and monitors
    output logic chip_reset_n_out,
    output logic cpu_reset_n_out,
    output logic [31:0] reset_vector_addr_out,
    output logic por_monitor_en_out,
    output logic core_brownout_arm_out,
    output logic regulator_low_power_out,
    // I/O pin enables
    input wire logic [srs_pkg::GPIO_COUNT-1:0] gpio_oe_req_in,
    output logic [srs_pkg::GPIO_COUNT-1:0] gpio_oe_out
);
    import srs_pkg::*;

    // ****************************************
    // Pin synchronisers and start-up clock
    // ****************************************
    logic power_stable_s;
    logic por_below_s;
    logic core_bo_s;
    logic osc_s;
    logic div_clk;
    logic div_rise;

    srs_sync2 #(
        .WIDTH(4)
    ) u_sync (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({power_stable_in, por_below_threshold_in, core_brownout_in, internal_rc_oscillator_in}),
        .sync_out({power_stable_s, por_below_s, core_bo_s, osc_s})
    );

    typedef enum logic [2:0] {
        ST_POWER_WAIT,
        ST_CLK_START,
        ST_CAL_READ,
        ST_USER_READ,
        ST_RELEASE,
        ST_RUN
    } srs_state_e;

    srs_state_e state;
    srs_state_e next_state;

    srs_clk_div u_div (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .osc_in(osc_s),
        .run_in(state != ST_POWER_WAIT),
        .div_clk_out(div_clk),
        .div_rise_out(div_rise)
    );

    // ****************************************
    // Sequence state
    // ****************************************
    logic [SETTLE_W-1:0] settle_cnt;
    logic [SETTLE_W-1:0] next_settle_cnt;
    logic [1:0] edge_cnt;
    logic [1:0] next_edge_cnt;
    logic [3:0] word_idx;
    logic [3:0] next_word_idx;
    srs_nvm_req_s next_nvm_req;
    srs_cal_write_s next_cal_write;
    logic [63:0] next_user_cfg;
    logic next_user_cfg_valid;
    logic next_chip_reset_n;
    logic next_cpu_reset_n;
    logic next_core_bo_arm;
    logic fault;

    always_comb
    begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_edge_cnt = edge_cnt;
        next_word_idx = word_idx;
        next_nvm_req = nvm_req_out;
        next_cal_write = '0;
        next_user_cfg = user_cfg_out;
        next_user_cfg_valid = user_cfg_valid_out;
        next_chip_reset_n = chip_reset_n_out;
        next_cpu_reset_n = cpu_reset_n_out;
        next_core_bo_arm = core_brownout_arm_out;
        // Brown-out only counts once armed; before that the core supply may still be settling
        fault = por_below_s || (core_brownout_arm_out && core_bo_s);
        if (fault)
        begin
            // Restart from the top; a user row written since is only picked up now
            next_state = ST_POWER_WAIT;
            next_settle_cnt = '0;
            next_chip_reset_n = 1'b0;
            next_cpu_reset_n = 1'b0;
            next_core_bo_arm = 1'b0;
            next_nvm_req = '0;
            next_user_cfg_valid = 1'b0;
        end
        else
        begin
            unique case (state)
                ST_POWER_WAIT:
                begin
                    next_chip_reset_n = 1'b0;
                    if (!power_stable_s)
                    begin
                        next_settle_cnt = '0;
                    end
                    else if (settle_cnt == SETTLE_LAST)
                    begin
                        next_state = ST_CLK_START;
                        next_chip_reset_n = 1'b1;
                        next_edge_cnt = '0;
                    end
                    else
                    begin
                        next_settle_cnt = settle_cnt + SETTLE_W'(1);
                    end
                end
                ST_CLK_START:
                begin
                    if (div_rise)
                    begin
                        // Wait for running start-up clock before loading anything
                        if (edge_cnt == CLK_EDGES_LAST)
                        begin
                            next_state = ST_CAL_READ;
                            next_word_idx = '0;
                        end
                        else
                        begin
                            next_edge_cnt = edge_cnt + 2'h1;
                        end
                    end
                end
                ST_CAL_READ:
                begin
                    // Request drops for a cycle after each answer so every word is a fresh request
                    if (!nvm_req_out.valid)
                    begin
                        next_nvm_req.valid = 1'b1;
                        next_nvm_req.addr = AUTO_CAL_ADDR + NVM_ADDR_W'({word_idx, 2'b00});
                    end
                    else if (nvm_rsp_in.valid)
                    begin
                        next_nvm_req.valid = 1'b0;
                        next_cal_write.valid = 1'b1;
                        next_cal_write.index = word_idx;
                        next_cal_write.data = nvm_rsp_in.data;
                        if (word_idx == CAL_WORDS_LAST)
                        begin
                            next_state = ST_USER_READ;
                            next_word_idx = '0;
                        end
                        else
                        begin
                            next_word_idx = word_idx + 4'h1;
                        end
                    end
                end
                ST_USER_READ:
                begin
                    if (!nvm_req_out.valid)
                    begin
                        next_nvm_req.valid = 1'b1;
                        next_nvm_req.addr = USER_ROW_ADDR + NVM_ADDR_W'({word_idx, 2'b00});
                    end
                    else if (nvm_rsp_in.valid)
                    begin
                        next_nvm_req.valid = 1'b0;
                        // User row is copied only here, so later writes wait for a reset
                        if (word_idx == USER_WORDS_LAST)
                        begin
                            next_user_cfg[63:32] = nvm_rsp_in.data;
                            next_user_cfg_valid = 1'b1;
                            next_state = ST_RELEASE;
                        end
                        else
                        begin
                            next_user_cfg[31:0] = nvm_rsp_in.data;
                            next_word_idx = word_idx + 4'h1;
                        end
                    end
                end
                ST_RELEASE:
                begin
                    // Align release to the start-up clock so the core sees a clean first edge
                    if (div_rise)
                    begin
                        next_cpu_reset_n = 1'b1;
                        next_core_bo_arm = 1'b1;
                        next_state = ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    next_core_bo_arm = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= ST_POWER_WAIT;
            settle_cnt <= '0;
            edge_cnt <= '0;
            word_idx <= '0;
            nvm_req_out <= '0;
            cal_write_out <= '0;
            user_cfg_out <= '0;
            user_cfg_valid_out <= 1'b0;
            chip_reset_n_out <= 1'b0;
            cpu_reset_n_out <= 1'b0;
            core_brownout_arm_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            edge_cnt <= next_edge_cnt;
            word_idx <= next_word_idx;
            nvm_req_out <= next_nvm_req;
            cal_write_out <= next_cal_write;
            user_cfg_out <= next_user_cfg;
            user_cfg_valid_out <= next_user_cfg_valid;
            chip_reset_n_out <= next_chip_reset_n;
            cpu_reset_n_out <= next_cpu_reset_n;
            core_brownout_arm_out <= next_core_bo_arm;
        end
    end

    // ****************************************
    // Clock defaults, pins and regulator
    // ****************************************
    logic next_gclk0;
    logic [GPIO_COUNT-1:0] next_gpio_oe;
    logic next_reg_lp;

    always_comb
    begin
        // Forced low on a fault so the divider's two-cycle lag never shows in power wait
        next_gclk0 = (fault || state == ST_POWER_WAIT) ? 1'b0 : div_clk;
        // Pins stay undriven for as long as the core is held
        next_gpio_oe = cpu_reset_n_out ? gpio_oe_req_in : '0;
        // Low power only while running and asked to sleep; normal through start-up
        next_reg_lp = cpu_reset_n_out && standby_req_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gclk0_clk_out <= 1'b0;
            pm_clk_src_out <= PM_SRC_GEN0;
            sync_clk_div_out <= SYNC_DIV_NONE;
            gclk_chan_en_out <= GCLK_EN_RESET;
            reset_vector_addr_out <= RESET_VECTOR_ADDR;
            por_monitor_en_out <= 1'b1;
            gpio_oe_out <= '0;
            regulator_low_power_out <= 1'b0;
        end
        else
        begin
            gclk0_clk_out <= next_gclk0;
            pm_clk_src_out <= PM_SRC_GEN0;
            sync_clk_div_out <= SYNC_DIV_NONE;
            gclk_chan_en_out <= GCLK_EN_RESET;
            // Fixed map: no remap input exists, so boot cannot move flash
            reset_vector_addr_out <= RESET_VECTOR_ADDR;
            // No port can clear this
            por_monitor_en_out <= 1'b1;
            gpio_oe_out <= next_gpio_oe;
            regulator_low_power_out <= next_reg_lp;
        end
    end
endmodule // srs_startup_reset_sequencer
`default_nettype wire

// *** logic/srs_pkg.sv ***
// Shared constants and carrier types of the start-up reset sequencer
package srs_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int POWER_SETTLE_NS = 1000;
    // Least time, so round up
    localparam int SETTLE_CYCLES = (POWER_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);
    localparam int OSC_DIVIDE = 8;
    localparam logic [1:0] DIV_HALF_LAST = 2'(OSC_DIVIDE / 2 - 1);
    localparam logic [1:0] CLK_EDGES_LAST = 2'h1;

    // ****************************************
    // Address map and nonvolatile rows
    // ****************************************
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] RESET_VECTOR_ADDR = FLASH_BASE;
    localparam int NVM_ADDR_W = 24;
    localparam logic [NVM_ADDR_W-1:0] USER_ROW_ADDR = 24'h80_4000;
    localparam logic [NVM_ADDR_W-1:0] AUTO_CAL_ADDR = 24'h80_6000;
    localparam logic [3:0] CAL_WORDS_LAST = 4'h3;
    localparam logic [3:0] USER_WORDS_LAST = 4'h1;

    // ****************************************
    // Clock and pin defaults
    // ****************************************
    localparam int GCLK_CHANNELS = 16;
    localparam int WDT_CHANNEL = 3;
    localparam logic [GCLK_CHANNELS-1:0] GCLK_EN_RESET = GCLK_CHANNELS'(1) << WDT_CHANNEL;
    localparam logic [3:0] PM_SRC_GEN0 = 4'h0;
    localparam logic [2:0] SYNC_DIV_NONE = 3'h0;
    localparam int GPIO_COUNT = 32;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic valid;
        logic [NVM_ADDR_W-1:0] addr;
    } srs_nvm_req_s;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } srs_nvm_rsp_s;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [31:0] data;
    } srs_cal_write_s;

endpackage

// *** logic/srs_sync2.sv ***
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module srs_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Only the second stage is read by anything
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule // srs_sync2
`default_nettype wire

// *** logic/srs_clk_div.sv ***
// Divide-by-eight of the sampled internal oscillator
`timescale 1ns/1ps
`default_nettype none
module srs_clk_div (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Oscillator level and enable
    input wire logic osc_in,
    input wire logic run_in,
    // Divided clock
    output logic div_clk_out,
    output logic div_rise_out
);
    import srs_pkg::*;

    logic osc_prev;
    logic [1:0] cnt;
    logic next_osc_prev;
    logic [1:0] next_cnt;
    logic next_div_clk;
    logic next_div_rise;

    always_comb
    begin
        next_osc_prev = osc_in;
        next_cnt = cnt;
        next_div_clk = div_clk_out;
        next_div_rise = 1'b0;
        if (!run_in)
        begin
            next_cnt = '0;
            next_div_clk = 1'b0;
        end
        else if (osc_in && !osc_prev)
        begin
            // Toggle every fourth oscillator edge gives a period of eight
            if (cnt == DIV_HALF_LAST)
            begin
                next_cnt = '0;
                next_div_clk = !div_clk_out;
                next_div_rise = !div_clk_out;
            end
            else
            begin
                next_cnt = cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            osc_prev <= 1'b0;
            cnt <= '0;
            div_clk_out <= 1'b0;
            div_rise_out <= 1'b0;
        end
        else
        begin
            osc_prev <= next_osc_prev;
            cnt <= next_cnt;
            div_clk_out <= next_div_clk;
            div_rise_out <= next_div_rise;
        end
    end
endmodule // srs_clk_div
`default_nettype wire

// *** dv/srs_chk_chk.sv ***
// Port checker of the start-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
module srs_chk
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Watched inputs
    input wire logic power_stable_in,
    input wire logic por_below_threshold_in,
    input wire logic standby_req_in,
    input wire srs_pkg::srs_nvm_rsp_s nvm_rsp_in,
    // Watched outputs
    input wire srs_pkg::srs_nvm_req_s nvm_req_out,
    input wire srs_pkg::srs_cal_write_s cal_write_out,
    input wire logic [63:0] user_cfg_out,
    input wire logic gclk0_clk_out,
    input wire logic [3:0] pm_clk_src_out,
    input wire logic [2:0] sync_clk_div_out,
    input wire logic [srs_pkg::GCLK_CHANNELS-1:0] gclk_chan_en_out,
    input wire logic chip_reset_n_out,
    input wire logic cpu_reset_n_out,
    input wire logic [31:0] reset_vector_addr_out,
    input wire logic por_monitor_en_out,
    input wire logic core_brownout_arm_out,
    input wire logic regulator_low_power_out,
    input wire logic [srs_pkg::GPIO_COUNT-1:0] gpio_oe_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ****************************************
    // Consecutive stable supply cycles, saturating
    // ****************************************
    logic [8:0] stable_cnt;
    logic [8:0] next_stable_cnt;
    always_comb
    begin
        next_stable_cnt = stable_cnt;
        if (!power_stable_in)
            next_stable_cnt = 9'h000;
        else if (stable_cnt != 9'h1FF)
            next_stable_cnt = stable_cnt + 9'h001;
    end
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            stable_cnt <= 9'h000;
        else
            stable_cnt <= next_stable_cnt;
    end
    // ****************************************
    // Assertions
    // ****************************************
    sequence s_cal_answer;
        nvm_req_out.valid && nvm_rsp_in.valid && nvm_req_out.addr[13];
    endsequence
    a_settle_before_release: assert property (
        $rose(chip_reset_n_out) |-> stable_cnt >= 9'h0FA) else $error("chip released too early");
    a_gclk_quiet_wait: assert property (
        !chip_reset_n_out && !$past(chip_reset_n_out) |-> !gclk0_clk_out) else $error("start clock runs in reset");
    a_fixed_clock_map: assert property (
        pm_clk_src_out == PM_SRC_GEN0 && sync_clk_div_out == SYNC_DIV_NONE && gclk_chan_en_out == GCLK_EN_RESET
        && reset_vector_addr_out == RESET_VECTOR_ADDR) else $error("fixed clock or vector setting changed");
    a_gpio_stay_float: assert property (
        !cpu_reset_n_out && !$past(cpu_reset_n_out) |-> gpio_oe_out == '0) else $error("pin driven in reset");
    a_por_always_on: assert property (
        por_monitor_en_out) else $error("power-on monitor disabled");
    a_por_chip_reset: assert property (
        por_below_threshold_in [*5] |-> !chip_reset_n_out && !cpu_reset_n_out) else $error("undervoltage ignored");
    a_arm_at_release: assert property (
        $rose(core_brownout_arm_out) |-> $rose(cpu_reset_n_out)) else $error("brown-out armed off release");
    a_cal_write_copy: assert property (
        s_cal_answer |=> cal_write_out.valid && !nvm_req_out.valid && cal_write_out.data == $past(nvm_rsp_in.data)
        && cal_write_out.index == {2'h0, $past(nvm_req_out.addr[3:2])}) else $error("calibration write wrong");
    a_cal_needs_answer: assert property (
        cal_write_out.valid |-> $past(nvm_rsp_in.valid) && $past(nvm_req_out.valid)) else $error("stray cal write");
    a_req_holds_addr: assert property (
        nvm_req_out.valid && !nvm_rsp_in.valid |=> !chip_reset_n_out
        || (nvm_req_out.valid && $stable(nvm_req_out.addr))) else $error("read request dropped");
    a_regulator_mode: assert property (
        cpu_reset_n_out && $past(cpu_reset_n_out) |-> regulator_low_power_out == $past(standby_req_in))
        else $error("regulator mode wrong");
    a_cfg_frozen_run: assert property (
        cpu_reset_n_out && $past(cpu_reset_n_out) |-> $stable(user_cfg_out)) else $error("user row reloaded");
    a_release_order: assert property (
        cpu_reset_n_out |-> chip_reset_n_out) else $error("core released in chip reset");
endmodule // srs_chk
bind srs_startup_reset_sequencer srs_chk u_chk (.ref_clk_in, .rst_n_in, .power_stable_in, .por_below_threshold_in,
    .standby_req_in, .nvm_rsp_in, .nvm_req_out, .cal_write_out, .user_cfg_out, .gclk0_clk_out, .pm_clk_src_out,
    .sync_clk_div_out, .gclk_chan_en_out, .chip_reset_n_out, .cpu_reset_n_out, .reset_vector_addr_out,
    .por_monitor_en_out, .core_brownout_arm_out, .regulator_low_power_out, .gpio_oe_out);
`default_nettype wire

// *** dv/srs_nvm_model.sv ***
// Behavioural nonvolatile memory answering the sequencer read port
`timescale 1ns/1ps
`default_nettype none
module srs_nvm_model
    import srs_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Row words and answer delay
    input wire logic [5:0][31:0] rows_in,
    input wire logic [2:0] delay_in,
    // Read port
    input wire srs_pkg::srs_nvm_req_s req_in,
    output var srs_pkg::srs_nvm_rsp_s rsp_out
);
    logic [2:0] wait_cnt;
    // Launch after the falling edge so the sequencer samples settled values
    always @(negedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rsp_out <= '0;
            wait_cnt <= 3'h0;
        end
        else if (rsp_out.valid || !req_in.valid)
        begin
            // Bus never keeps the last word once the answer is gone
            rsp_out.valid <= 1'b0;
            rsp_out.data <= ~rsp_out.data;
            wait_cnt <= delay_in;
        end
        else if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
        else
        begin
            rsp_out.valid <= 1'b1;
            rsp_out.data <= rows_in[req_in.addr[13] ? {1'b0, req_in.addr[3:2]} : {2'h2, req_in.addr[2]}];
        end
    end
endmodule // srs_nvm_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the start-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srs_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic power_stable_in = 1'b0;
    logic por_low = 1'b0;
    logic bod = 1'b0;
    logic osc = 1'b0;
    logic standby = 1'b0;
    logic [31:0] oe_req = 32'h0000_0000;
    logic [5:0][31:0] rows = '0;
    logic [2:0] delay = 3'h0;
    srs_nvm_req_s nvm_req;
    srs_nvm_rsp_s nvm_rsp;
    srs_cal_write_s cal_wr;
    srs_cal_write_s cal_q[$];
    logic [63:0] user_cfg;
    logic [63:0] exp_cfg;
    logic [31:0] gpio_oe;
    logic cfg_ok, gclk0, chip_rst_n, cpu_rst_n, bo_arm, reg_lp;
    logic [3:0] pm_src;
    logic [2:0] sync_div;
    logic [GCLK_CHANNELS-1:0] chan_en;
    logic [31:0] rst_vec;
    logic por_en;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 79946;
    int n;
    srs_startup_reset_sequencer dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .power_stable_in(power_stable_in), .por_below_threshold_in(por_low), .core_brownout_in(bod),
        .internal_rc_oscillator_in(osc), .standby_req_in(standby), .nvm_req_out(nvm_req), .nvm_rsp_in(nvm_rsp),
        .cal_write_out(cal_wr), .user_cfg_out(user_cfg), .user_cfg_valid_out(cfg_ok), .gclk0_clk_out(gclk0),
        .pm_clk_src_out(pm_src), .sync_clk_div_out(sync_div), .gclk_chan_en_out(chan_en),
        .chip_reset_n_out(chip_rst_n), .cpu_reset_n_out(cpu_rst_n), .reset_vector_addr_out(rst_vec),
        .por_monitor_en_out(por_en),
        .core_brownout_arm_out(bo_arm), .regulator_low_power_out(reg_lp), .gpio_oe_req_in(oe_req),
        .gpio_oe_out(gpio_oe));
    srs_nvm_model u_nvm (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .rows_in(rows), .delay_in(delay),
        .req_in(nvm_req), .rsp_out(nvm_rsp));
    always #2 ref_clk_in = ~ref_clk_in;
    // 8 MHz oscillator, phase unrelated to the reference clock
    initial
    begin
        #7;
        forever #62.5 osc = ~osc;
    end
    always @(negedge ref_clk_in)
    begin
        cycles++;
        if (cal_wr.valid === 1'b1)
            cal_q.push_back(cal_wr);
        if (cycles == 20000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // Bounded wait for a level on the chip, core or start clock output
    task automatic wait_lvl(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while ((sel == 0 ? chip_rst_n : sel == 1 ? cpu_rst_n : gclk0) !== lvl && cnt < 4000)
        begin
            @(negedge ref_clk_in);
            cnt++;
        end
    endtask
    // Start clock half period: half the divide ratio of 125 ns oscillator periods
    function automatic int half_cycles();
        return OSC_DIVIDE * 62500 / CLK_PERIOD_PS;
    endfunction
    task automatic boot();
        for (int i = 0; i < 6; i++)
            rows[i] = $random(seed);
        cal_q = {};
        power_stable_in = 1'b1;
        repeat (100) @(negedge ref_clk_in);
        check_val(chip_rst_n, 1'b0);
        power_stable_in = 1'b0;
        @(negedge ref_clk_in);
        power_stable_in = 1'b1;
        wait_lvl(0, 1'b1, n);
        check_rng(n, 251, 254);
        bod = 1'b0;
        wait_lvl(2, 1'b1, n);
        wait_lvl(2, 1'b0, n);
        wait_lvl(2, 1'b1, n);
        check_rng(n, half_cycles() - 1, half_cycles() + 1);
        wait_lvl(1, 1'b1, n);
        check_val(cal_q.size(), 4);
        foreach (cal_q[i])
            check_val({cal_q[i].index, cal_q[i].data}, {4'(i), rows[i]});
        check_val(user_cfg, {rows[5], rows[4]});
        check_val({cfg_ok, bo_arm, chip_rst_n, cpu_rst_n}, 4'hF);
        check_val({pm_src, sync_div, chan_en}, {PM_SRC_GEN0, SYNC_DIV_NONE, GCLK_EN_RESET});
        check_val({rst_vec, por_en}, {RESET_VECTOR_ADDR, 1'b1});
    endtask
    task automatic traffic();
        exp_cfg = {rows[5], rows[4]};
        rows[4] = ~rows[4];
        repeat (24)
        begin
            @(negedge ref_clk_in);
            check_val(gpio_oe, oe_req);
            check_val(reg_lp, standby);
            oe_req = $random(seed);
            standby = 1'($random(seed));
        end
        check_val(user_cfg, exp_cfg);
    endtask
    task automatic complete_run();
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        oe_req = 32'hFFFF_FFFF;
        repeat (5) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        check_val({chip_rst_n, cpu_rst_n, gpio_oe}, 34'h0);
        boot();
        traffic();
        bod = 1'b1;
        wait_lvl(0, 1'b0, n);
        check_rng(n, 1, 5);
        check_val({cpu_rst_n, bo_arm}, 2'h0);
        bod = 1'b0;
        delay = 3'h7;
        boot();
        traffic();
        por_low = 1'b1;
        wait_lvl(0, 1'b0, n);
        check_rng(n, 1, 5);
        por_low = 1'b0;
        // Brown-out held high in the power wait must be ignored until armed
        bod = 1'b1;
        delay = 3'($random(seed));
        boot();
        traffic();
        rst_n_in = 1'b0;
        @(negedge ref_clk_in);
        check_val({chip_rst_n, cpu_rst_n}, 2'h0);
        rst_n_in = 1'b1;
        boot();
        complete_run();
    end
endmodule // tb
`default_nettype wire
